// ---- hw/lbs_sorter.sv ----
// comparator sorting core: nine primary ranges, one secondary range, low capacitance reject
//
// Functional notes
// RULE1: secondary outside enabled range, primary matched, auxiliary off gives no-range result.
// RULE2: primary matched, secondary outside enabled range, auxiliary on gives secondary-fail.
// RULE3: no primary range matched gives no-range result whenever comparator on and no overload.
// RULE4: low capacitance flagged when enabled and value at or below boundary.
// RULE5: with comparator on, sorting still runs but display shows low capacitance.
// RULE6: low capacitance drives reject pin low alongside the normal result pins.
// RULE7: boundary is a percentage of the applicable range full scale.
// RULE8: auto range uses smallest range: 100 pF at 1 kHz, 1 pF at 1 MHz.
// RULE9: fixed range uses the currently selected range.
// RULE10: nine primary ranges, each with enable, lower and upper limit.
// RULE11: one secondary range with enable and limits, used only when enabled.
// RULE12: writing first primary limits leaves its enable unchanged.
// RULE13: writing secondary limits leaves its enable unchanged.
// RULE14: low capacitance check has its own enable; off means never flagged.
// RULE15: upper limit not above lower limit disables the range.
// RULE16: overlapping ranges resolve to the lowest numbered match.
// RULE17: tolerance mode reads primary limits as absolute or percent deviations.
// RULE18: overload gives no sorting result for that measurement.
// RULE19: result evaluated once per measurement and held until the next.
// RULE20: match needs enabled range and value inside limits inclusive.
`timescale 1ns/1ns
`include "lbs_map.svh"
module lbs_sorter #(
  parameter int W     = 32,
  parameter int NBINS = 9
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output      logic [31:0]           reg_rdata,
  // measurement in
  input  wire logic                  meas_valid,
  input  wire logic                  meas_overload,
  input  wire logic signed [W-1:0]   parallel_capacitance,
  input  wire logic signed [W-1:0]   secondary_value,
  // result
  output      logic                  result_strobe,
  output      lbs_pkg::lbs_kind_e    result_kind,
  output      logic [3:0]            result_bin,
  output      lbs_pkg::lbs_disp_e    display_code,
  output      logic                  low_cap_indication,
  output      logic                  overload_flag,
  // handler pins, active low
  output      logic [NBINS-1:0]      primary_limit_ranges_n,
  output      logic                  secondary_fail_result_n,
  output      logic                  no_range_result_n,
  output      logic                  low_cap_reject_n
);

  typedef struct packed {
    logic                        comp_en;
    logic                        aux_en;
    logic                        low_cap_indication_en;
    logic                        sec_en;
    lbs_pkg::lbs_tol_e           tol_mode;
    logic                        auto_range;
    logic                        freq_1mhz;
    logic [2:0]                  range_sel;
    logic [NBINS-1:0]            pri_en;
    logic [W-1:0]                ref_val;
    logic [7:0]                  low_cap_indication_pct;
    logic [NBINS-1:0][W-1:0]     pri_lo;
    logic [NBINS-1:0][W-1:0]     pri_hi;
    logic [W-1:0]                sec_lo;
    logic [W-1:0]                sec_hi;
    lbs_pkg::lbs_kind_e          kind;
    logic [3:0]                  bin_num;
    lbs_pkg::lbs_disp_e          disp;
    logic                        low_cap;
    logic                        overload;
    logic                        strobe;
    logic [NBINS-1:0]            bin_n;
    logic                        sec_fail_n;
    logic                        no_range_n;
    logic                        low_cap_n;
    logic [31:0]                 rdata;
  } lbs_state_s;

  lbs_state_s              st_reg;
  lbs_state_s              st_next;
  logic [NBINS-1:0]        pri_hit;
  logic                    sec_hit;
  logic signed [W-1:0]     low_cap_indication_boundary;
  logic                    low_cap_indication_now;
  logic [31:0]             ctrl_word;

  ////////////////////////////////////////////////////////////////////////////////
  // limit conversion and range checks

  // deviation to absolute limit; percent is in hundredths of a percent
  function automatic logic signed [W-1:0] tol_apply(
    input lbs_pkg::lbs_tol_e   mode,
    input logic signed [W-1:0] refv,
    input logic signed [W-1:0] dev
  );
    logic signed [2*W-1:0] prod;
    prod = (2*W)'(refv) * (2*W)'(dev);
    case (mode)
      lbs_pkg::TOL_ABS: tol_apply = W'(refv + dev);
      lbs_pkg::TOL_PCT: tol_apply = W'(refv + W'(prod / (2*W)'(`LBS_TOL_PCT_SCALE)));
      default:          tol_apply = dev;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < NBINS; g++) begin : g_bin
      logic signed [W-1:0] lo_eff;
      logic signed [W-1:0] hi_eff;
      // tolerance applies to the primary ranges only (see RULE17)
      assign lo_eff = tol_apply(st_reg.tol_mode, $signed(st_reg.ref_val),
                                $signed(st_reg.pri_lo[g]));
      assign hi_eff = tol_apply(st_reg.tol_mode, $signed(st_reg.ref_val),
                                $signed(st_reg.pri_hi[g]));
      lbs_range_check #(.W(W)) u_pri (  // see RULE10
        .enable (st_reg.pri_en[g]),
        .lower  (lo_eff),
        .upper  (hi_eff),
        .value  (parallel_capacitance),
        .hit    (pri_hit[g])
      );
    end
  endgenerate

  lbs_range_check #(.W(W)) u_sec (  // see RULE11
    .enable (st_reg.sec_en),
    .lower  ($signed(st_reg.sec_lo)),
    .upper  ($signed(st_reg.sec_hi)),
    .value  (secondary_value),
    .hit    (sec_hit)
  );

  lbs_low_cap_indication_threshold #(.W(W)) u_low_cap_indication (
    .auto_range (st_reg.auto_range),
    .freq_1mhz  (st_reg.freq_1mhz),
    .range_sel  (st_reg.range_sel),
    .pct        (st_reg.low_cap_indication_pct),
    .boundary   (low_cap_indication_boundary)
  );

  assign low_cap_indication_now = st_reg.low_cap_indication_en && (parallel_capacitance <= low_cap_indication_boundary); // see RULE4, RULE14

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`LBS_CTRL_COMP_EN]   = st_reg.comp_en;
    ctrl_word[`LBS_CTRL_AUX_EN]    = st_reg.aux_en;
    ctrl_word[`LBS_CTRL_LOW_CAP_INDICATION_EN]   = st_reg.low_cap_indication_en;
    ctrl_word[`LBS_CTRL_SEC_EN]    = st_reg.sec_en;
    ctrl_word[`LBS_CTRL_TOL_LSB +: 2] = st_reg.tol_mode;
    ctrl_word[`LBS_CTRL_AUTO_RNG]  = st_reg.auto_range;
    ctrl_word[`LBS_CTRL_FREQ_1MHZ] = st_reg.freq_1mhz;
    ctrl_word[`LBS_CTRL_RNG_LSB +: 3] = st_reg.range_sel;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] first_bin;
    logic       any_hit;
    first_bin = 4'h0;
    any_hit   = |pri_hit;
    st_next        = st_reg;
    st_next.strobe = 1'b0;
    st_next.rdata  = 32'h0000_0000;

    // lowest numbered match wins on overlap (see RULE16)
    for (int i = NBINS - 1; i >= 0; i--) begin
      if (pri_hit[i]) begin
        first_bin = 4'(i + 1);
      end
    end

    if (reg_wr) begin
      case (reg_addr)
        `LBS_CTRL_OFS: begin
          st_next.comp_en    = reg_wdata[`LBS_CTRL_COMP_EN];
          st_next.aux_en     = reg_wdata[`LBS_CTRL_AUX_EN];
          st_next.low_cap_indication_en    = reg_wdata[`LBS_CTRL_LOW_CAP_INDICATION_EN]; // see RULE14
          st_next.sec_en     = reg_wdata[`LBS_CTRL_SEC_EN];
          st_next.tol_mode   = lbs_pkg::lbs_tol_e'(reg_wdata[`LBS_CTRL_TOL_LSB +: 2]);
          st_next.auto_range = reg_wdata[`LBS_CTRL_AUTO_RNG];
          st_next.freq_1mhz  = reg_wdata[`LBS_CTRL_FREQ_1MHZ];
          st_next.range_sel  = reg_wdata[`LBS_CTRL_RNG_LSB +: 3];
        end
        `LBS_PRI_EN_OFS:   st_next.pri_en   = reg_wdata[NBINS-1:0];
        `LBS_REF_OFS:      st_next.ref_val  = reg_wdata[W-1:0];
        `LBS_LOW_CAP_INDICATION_PCT_OFS: st_next.low_cap_indication_pct = reg_wdata[7:0];
        // limit writes touch limits only, enables live elsewhere (see RULE13)
        `LBS_SEC_LO_OFS:   st_next.sec_lo   = reg_wdata[W-1:0];
        `LBS_SEC_HI_OFS:   st_next.sec_hi   = reg_wdata[W-1:0];
        default: begin
          // see RULE12
          for (int i = 0; i < NBINS; i++) begin
            if (reg_addr == 8'(`LBS_PRI_LO_BASE + 4 * i)) begin
              st_next.pri_lo[i] = reg_wdata[W-1:0];
            end
            if (reg_addr == 8'(`LBS_PRI_HI_BASE + 4 * i)) begin
              st_next.pri_hi[i] = reg_wdata[W-1:0];
            end
          end
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        `LBS_CTRL_OFS:     st_next.rdata = ctrl_word;
        `LBS_PRI_EN_OFS:   st_next.rdata = 32'(st_reg.pri_en);
        `LBS_REF_OFS:      st_next.rdata = 32'(st_reg.ref_val);
        `LBS_LOW_CAP_INDICATION_PCT_OFS: st_next.rdata = 32'(st_reg.low_cap_indication_pct);
        `LBS_SEC_LO_OFS:   st_next.rdata = 32'(st_reg.sec_lo);
        `LBS_SEC_HI_OFS:   st_next.rdata = 32'(st_reg.sec_hi);
        `LBS_STATUS_OFS:
          st_next.rdata = {16'h0000, st_reg.overload, st_reg.low_cap, 3'(st_reg.disp),
                           2'(st_reg.kind), 5'h00, st_reg.bin_num};
        default: begin
          // unmapped addresses read zero
          for (int i = 0; i < NBINS; i++) begin
            if (reg_addr == 8'(`LBS_PRI_LO_BASE + 4 * i)) begin
              st_next.rdata = 32'(st_reg.pri_lo[i]);
            end
            if (reg_addr == 8'(`LBS_PRI_HI_BASE + 4 * i)) begin
              st_next.rdata = 32'(st_reg.pri_hi[i]);
            end
          end
        end
      endcase
    end

    // one evaluation per measurement, held until the next (see RULE19)
    if (meas_valid) begin
      st_next.strobe     = 1'b1;
      st_next.bin_n      = '1;
      st_next.sec_fail_n = 1'b1;
      st_next.no_range_n = 1'b1;
      st_next.bin_num    = 4'h0;
      st_next.kind       = lbs_pkg::KIND_NONE;
      st_next.disp       = lbs_pkg::DISP_NONE;
      st_next.overload   = meas_overload;
      st_next.low_cap    = 1'b0;
      st_next.low_cap_n  = 1'b1;
      if (meas_overload) begin
        st_next.disp = lbs_pkg::DISP_OVLD; // see RULE18
      end else begin
        st_next.low_cap   = low_cap_indication_now;
        st_next.low_cap_n = !low_cap_indication_now; // see RULE6
        if (st_reg.comp_en) begin
          if (!any_hit) begin
            st_next.kind = lbs_pkg::KIND_NO_RANGE; // see RULE3
          end else if (st_reg.sec_en && !sec_hit) begin
            // see RULE1, RULE2
            st_next.kind = st_reg.aux_en ? lbs_pkg::KIND_SEC_FAIL : lbs_pkg::KIND_NO_RANGE;
          end else begin
            st_next.kind    = lbs_pkg::KIND_BIN;
            st_next.bin_num = first_bin;
            st_next.bin_n[first_bin - 4'h1] = 1'b0;
          end
          st_next.sec_fail_n = (st_next.kind != lbs_pkg::KIND_SEC_FAIL);
          st_next.no_range_n = (st_next.kind != lbs_pkg::KIND_NO_RANGE);
          case (st_next.kind)
            lbs_pkg::KIND_BIN:      st_next.disp = lbs_pkg::DISP_BIN;
            lbs_pkg::KIND_SEC_FAIL: st_next.disp = lbs_pkg::DISP_SEC_FAIL;
            lbs_pkg::KIND_NO_RANGE: st_next.disp = lbs_pkg::DISP_NO_RANGE;
            default:                st_next.disp = lbs_pkg::DISP_NONE;
          endcase
          // sorting pins keep the normal result, only the display is replaced (see RULE5)
          if (low_cap_indication_now) begin
            st_next.disp = lbs_pkg::DISP_LOW_CAP_INDICATION;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg            <= '0;
      st_reg.tol_mode   <= lbs_pkg::TOL_OFF;
      st_reg.low_cap_indication_pct   <= `LBS_LOW_CAP_INDICATION_PCT_RESET;
      st_reg.bin_n      <= '1;
      st_reg.sec_fail_n <= 1'b1;
      st_reg.no_range_n <= 1'b1;
      st_reg.low_cap_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata               = st_reg.rdata;
  assign result_strobe           = st_reg.strobe;
  assign result_kind             = st_reg.kind;
  assign result_bin              = st_reg.bin_num;
  assign display_code            = st_reg.disp;
  assign low_cap_indication      = st_reg.low_cap;
  assign overload_flag           = st_reg.overload;
  assign primary_limit_ranges_n  = st_reg.bin_n;
  assign secondary_fail_result_n = st_reg.sec_fail_n;
  assign no_range_result_n       = st_reg.no_range_n;
  assign low_cap_reject_n        = st_reg.low_cap_n;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_NO_MATCH: assert property ( // see RULE3
    meas_valid && !meas_overload && st_reg.comp_en && pri_hit == '0
    |=> result_kind == lbs_pkg::KIND_NO_RANGE && !no_range_result_n)
    else $error("no primary match did not give no-range result");

  AST_AUX_OFF: assert property ( // see RULE1
    meas_valid && !meas_overload && st_reg.comp_en && pri_hit != '0 && st_reg.sec_en
    && !sec_hit && !st_reg.aux_en |=> result_kind == lbs_pkg::KIND_NO_RANGE)
    else $error("secondary fail with auxiliary off not no-range");

  AST_AUX_ON: assert property ( // see RULE2
    meas_valid && !meas_overload && st_reg.comp_en && pri_hit != '0 && st_reg.sec_en
    && !sec_hit && st_reg.aux_en |=> result_kind == lbs_pkg::KIND_SEC_FAIL
    && !secondary_fail_result_n && primary_limit_ranges_n == '1)
    else $error("secondary fail with auxiliary on not reported");

  AST_LOWEST_BIN: assert property ( // see RULE16
    meas_valid && !meas_overload && st_reg.comp_en && pri_hit[0] && (!st_reg.sec_en || sec_hit)
    |=> result_bin == 4'h1 && primary_limit_ranges_n == 9'h1fe)
    else $error("overlapping match not sorted to lowest range");

  AST_LOW_CAP_INDICATION_OFF: assert property ( // see RULE14
    meas_valid && !st_reg.low_cap_indication_en |=> !low_cap_indication && low_cap_reject_n)
    else $error("low capacitance flagged while check disabled");

  AST_LOW_CAP_INDICATION_PIN: assert property ( // see RULE6
    low_cap_indication |-> !low_cap_reject_n
    && (!$past(st_reg.comp_en) || result_kind != lbs_pkg::KIND_NONE))
    else $error("low capacitance pin or sorting result missing");

  AST_LOW_CAP_INDICATION_DISP: assert property ( // see RULE5
    meas_valid && !meas_overload && st_reg.comp_en && low_cap_indication_now
    |=> display_code == lbs_pkg::DISP_LOW_CAP_INDICATION && result_kind != lbs_pkg::KIND_NONE)
    else $error("low capacitance display not shown");

  AST_OVERLOAD: assert property ( // see RULE18
    meas_valid && meas_overload |=> result_kind == lbs_pkg::KIND_NONE && overload_flag
    && primary_limit_ranges_n == '1 && no_range_result_n && secondary_fail_result_n)
    else $error("overload still produced a sorting result");

  AST_HOLD: assert property ( // see RULE19
    meas_valid ##1 !meas_valid [*3] |=> $stable(result_kind) && $stable(result_bin)
    && !result_strobe)
    else $error("result changed without a measurement");

  AST_EN_KEEP: assert property ( // see RULE12
    reg_wr && (reg_addr == `LBS_PRI_LO_BASE || reg_addr == `LBS_PRI_HI_BASE)
    |=> st_reg.pri_en == $past(st_reg.pri_en))
    else $error("primary limit write changed range enable");

  AST_SEC_KEEP: assert property ( // see RULE13
    reg_wr && (reg_addr == `LBS_SEC_LO_OFS || reg_addr == `LBS_SEC_HI_OFS)
    |=> st_reg.sec_en == $past(st_reg.sec_en))
    else $error("secondary limit write changed range enable");

  CVR_BIN:   cover property (result_strobe && result_kind == lbs_pkg::KIND_BIN);
  CVR_AUX:   cover property (result_strobe && result_kind == lbs_pkg::KIND_SEC_FAIL);
  CVR_LOW_CAP_INDICATION:  cover property (result_strobe && display_code == lbs_pkg::DISP_LOW_CAP_INDICATION);
  CVR_OVLD:  cover property (result_strobe && overload_flag);

endmodule

// ---- hw/lbs_map.svh ----
// register offsets, field positions, reset values and scale constants of the limit sorter
`ifndef LBS_MAP_SVH
`define LBS_MAP_SVH

// register byte offsets
`define LBS_CTRL_OFS        8'h00
`define LBS_PRI_EN_OFS      8'h04
`define LBS_REF_OFS         8'h08
`define LBS_LOW_CAP_INDICATION_PCT_OFS    8'h0c
`define LBS_SEC_LO_OFS      8'h10
`define LBS_SEC_HI_OFS      8'h14
`define LBS_STATUS_OFS      8'h18
`define LBS_PRI_LO_BASE     8'h40
`define LBS_PRI_HI_BASE     8'h80

// control register fields
`define LBS_CTRL_COMP_EN    0
`define LBS_CTRL_AUX_EN     1
`define LBS_CTRL_LOW_CAP_INDICATION_EN    2
`define LBS_CTRL_SEC_EN     3
`define LBS_CTRL_TOL_LSB    4
`define LBS_CTRL_AUTO_RNG   6
`define LBS_CTRL_FREQ_1MHZ  7
`define LBS_CTRL_RNG_LSB    8

// reset values
`define LBS_CTRL_RESET      32'h0000_0000
`define LBS_LOW_CAP_INDICATION_PCT_RESET  8'h00

// scales: values in femtofarads, tolerance percent in hundredths of a percent
`define LBS_TOL_PCT_SCALE   10000
`define LBS_PCT_SCALE       100
`define LBS_FS_1PF_FF       1000
`define LBS_FS_100PF_FF     100000
`define LBS_RANGE_MAX       6

`endif

// ---- hw/lbs_pkg.sv ----
// types shared by the limit sorter modules
package lbs_pkg;

  typedef enum logic [1:0] {TOL_OFF, TOL_ABS, TOL_PCT} lbs_tol_e;

  typedef enum logic [1:0] {KIND_NONE, KIND_BIN, KIND_SEC_FAIL, KIND_NO_RANGE} lbs_kind_e;

  typedef enum logic [2:0] {
    DISP_NONE, DISP_BIN, DISP_SEC_FAIL, DISP_NO_RANGE, DISP_LOW_CAP_INDICATION, DISP_OVLD
  } lbs_disp_e;

endpackage

// ---- hw/lbs_range_check.sv ----
// one limit range: inclusive window check with enable
`timescale 1ns/1ns
module lbs_range_check #(
  parameter int W = 32
) (
  // range setup
  input  wire logic                enable,
  input  wire logic signed [W-1:0] lower,
  input  wire logic signed [W-1:0] upper,
  // measured value
  input  wire logic signed [W-1:0] value,
  // result
  output      logic                hit
);
  // upper not above lower acts as switched off (see RULE15)
  assign hit = enable && (upper > lower) && (value >= lower) && (value <= upper); // see RULE20
endmodule

// ---- hw/lbs_low_cap_indication_threshold.sv ----
// low capacitance boundary from range full scale and percentage
`timescale 1ns/1ns
`include "lbs_map.svh"
module lbs_low_cap_indication_threshold #(
  parameter int W = 32
) (
  // range setup
  input  wire logic                auto_range,
  input  wire logic                freq_1mhz,
  input  wire logic [2:0]          range_sel,
  input  wire logic [7:0]          pct,
  // boundary
  output      logic signed [W-1:0] boundary
);
  logic [63:0] full_scale;
  logic [63:0] prod;

  always_comb begin
    full_scale = 64'(`LBS_FS_1PF_FF);
    if (auto_range) begin
      // smallest range, not the one in use (see RULE8)
      full_scale = freq_1mhz ? 64'(`LBS_FS_1PF_FF) : 64'(`LBS_FS_100PF_FF);
    end else begin
      // selected range, clamped to the largest one (see RULE9)
      for (int i = 0; i < `LBS_RANGE_MAX; i++) begin
        if (i < int'(range_sel)) begin
          full_scale = full_scale * 64'h0000_0000_0000_000a;
        end
      end
    end
    prod = (full_scale * 64'(pct)) / 64'(`LBS_PCT_SCALE); // see RULE7
    boundary = W'(prod);
  end
endmodule

// ---- tb/lbs_handler_model.sv ----
// component handler model: latches the sorting pins on each result strobe
`timescale 1ns/1ns
module lbs_handler_model #(
  parameter int NBINS = 9
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // pins from the sorter
  input  wire logic             result_strobe,
  input  wire logic [NBINS-1:0] primary_limit_ranges_n,
  input  wire logic             secondary_fail_result_n,
  input  wire logic             no_range_result_n,
  input  wire logic             low_cap_reject_n,
  // latched judgment
  output      logic [NBINS-1:0] seen_bins_n,
  output      logic             seen_sec_fail_n,
  output      logic             seen_no_range_n,
  output      logic             seen_low_cap_n
);
  // pins are only trusted while the strobe marks a fresh judgment
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_bins_n     <= '1;
      seen_sec_fail_n <= 1'b1;
      seen_no_range_n <= 1'b1;
      seen_low_cap_n  <= 1'b1;
    end else if (result_strobe) begin
      seen_bins_n     <= primary_limit_ranges_n;
      seen_sec_fail_n <= secondary_fail_result_n;
      seen_no_range_n <= no_range_result_n;
      seen_low_cap_n  <= low_cap_reject_n;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the limit sorter
`timescale 1ns/1ns
`include "lbs_map.svh"
module tb_top;
  localparam lbs_pkg::lbs_kind_e K_NO = lbs_pkg::KIND_NONE;
  localparam lbs_pkg::lbs_kind_e K_BN = lbs_pkg::KIND_BIN;
  localparam lbs_pkg::lbs_kind_e K_SF = lbs_pkg::KIND_SEC_FAIL;
  localparam lbs_pkg::lbs_kind_e K_NR = lbs_pkg::KIND_NO_RANGE;
  localparam lbs_pkg::lbs_disp_e D_BN = lbs_pkg::DISP_BIN;
  localparam lbs_pkg::lbs_disp_e D_SF = lbs_pkg::DISP_SEC_FAIL;
  localparam lbs_pkg::lbs_disp_e D_NR = lbs_pkg::DISP_NO_RANGE;
  localparam lbs_pkg::lbs_disp_e D_LC = lbs_pkg::DISP_LOW_CAP_INDICATION;
  localparam lbs_pkg::lbs_disp_e D_OV = lbs_pkg::DISP_OVLD;
  logic               ref_clk;
  logic               reset_n;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic               meas_valid;
  logic               meas_overload;
  logic signed [31:0] pcap;
  logic signed [31:0] sval;
  logic               result_strobe;
  lbs_pkg::lbs_kind_e result_kind;
  logic [3:0]         result_bin;
  lbs_pkg::lbs_disp_e display_code;
  logic               low_cap_indication;
  logic               overload_flag;
  logic [8:0]         bins_n;
  logic               sec_n;
  logic               nr_n;
  logic               lc_n;
  logic [11:0]        h_pins;
  int                 miscompares;
  int                 n_compared;
  // low cap table: control word and expected boundary in femtofarads
  logic [31:0]        lc_ctrl [4] = '{32'h605, 32'h645, 32'h6c5, 32'h305};
  logic [31:0]        lc_bd   [4] = '{32'd10000000, 32'd1000, 32'd10, 32'd10000};

  lbs_sorter #(.W(32), .NBINS(9)) lbs_sorter_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_overload(meas_overload), .parallel_capacitance(pcap), .secondary_value(sval),
    .result_strobe(result_strobe), .result_kind(result_kind), .result_bin(result_bin),
    .display_code(display_code), .low_cap_indication(low_cap_indication),
    .overload_flag(overload_flag), .primary_limit_ranges_n(bins_n),
    .secondary_fail_result_n(sec_n), .no_range_result_n(nr_n), .low_cap_reject_n(lc_n));

  lbs_handler_model #(.NBINS(9)) lbs_handler_model_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .result_strobe(result_strobe),
    .primary_limit_ranges_n(bins_n), .secondary_fail_result_n(sec_n),
    .no_range_result_n(nr_n), .low_cap_reject_n(lc_n), .seen_bins_n(h_pins[11:3]),
    .seen_sec_fail_n(h_pins[2]), .seen_no_range_n(h_pins[1]), .seen_low_cap_n(h_pins[0]));

  always #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  function automatic logic [31:0] obs();
    return {8'h0, result_strobe, result_kind, result_bin, display_code,
            low_cap_indication, overload_flag, bins_n, sec_n, nr_n, lc_n};
  endfunction

  // one measurement; result checked in the strobe cycle and once more while it holds
  task automatic meas(input logic signed [31:0] p, input logic signed [31:0] s,
                      input logic ov, input lbs_pkg::lbs_kind_e k, input logic [3:0] b,
                      input lbs_pkg::lbs_disp_e d, input logic lc);
    logic [8:0]  eb;
    logic [31:0] ex;
    eb = (k == K_BN) ? ~(9'h001 << (b - 4'h1)) : 9'h1ff;
    ex = {8'h0, 1'b1, k, b, d, lc, ov, eb, k != K_SF, k != K_NR, ~lc};
    @(posedge ref_clk);
    meas_valid    <= 1'b1;
    meas_overload <= ov;
    pcap          <= p;
    sval          <= s;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    #1 chk(obs(), ex);
    @(posedge ref_clk);
    #1 chk(obs(), ex & ~32'h0080_0000);
    chk({20'h0, h_pins}, {20'h0, ex[11:0]});
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    meas_valid = 1'b0;
    meas_overload = 1'b0;
    pcap = 32'sh0;
    sval = 32'sh0;
    miscompares = 0;
    n_compared = 0;
    repeat (5) @(posedge ref_clk);
    #1 chk(obs(), 32'h0000_0fff);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(`LBS_CTRL_OFS, 32'h0);
    rdc(`LBS_STATUS_OFS, 32'h0);
    rdc(8'h3c, 32'h0);
    wr(`LBS_CTRL_OFS, 32'h1);
    wr(`LBS_PRI_EN_OFS, 32'h1ff);
    for (int i = 0; i < 9; i++) begin
      wr(`LBS_PRI_LO_BASE + 8'(4 * i), 32'(100000 * (i + 1)));
      wr(`LBS_PRI_HI_BASE + 8'(4 * i), 32'(100000 * (i + 1) + 50000));
    end
    for (int i = 0; i < 9; i++) begin
      meas(32'(100000 * (i + 1) + 50000), 0, 1'b0, K_BN, 4'(i + 1), D_BN, 1'b0);
    end
    rdc(`LBS_STATUS_OFS, 32'h0000_0a09);
    meas(950001, 0, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    meas(99999, 0, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    wr(`LBS_PRI_LO_BASE, 32'd100000);
    rdc(`LBS_PRI_EN_OFS, 32'h1ff);
    wr(`LBS_PRI_LO_BASE + 8'h04, 32'd120000);
    meas(130000, 0, 1'b0, K_BN, 4'h1, D_BN, 1'b0);
    meas(150001, 0, 1'b0, K_BN, 4'h2, D_BN, 1'b0);
    wr(`LBS_PRI_HI_BASE + 8'h08, 32'd300000);
    meas(300000, 0, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    wr(`LBS_PRI_EN_OFS, 32'h1fe);
    meas(100000, 0, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    wr(`LBS_PRI_EN_OFS, 32'h1ff);
    wr(`LBS_CTRL_OFS, 32'h9);
    wr(`LBS_SEC_LO_OFS, 32'd0);
    wr(`LBS_SEC_HI_OFS, 32'd10);
    rdc(`LBS_CTRL_OFS, 32'h9);
    meas(100000, 5, 1'b0, K_BN, 4'h1, D_BN, 1'b0);
    meas(100000, 20, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    wr(`LBS_CTRL_OFS, 32'hb);
    meas(100000, 20, 1'b0, K_SF, 4'h0, D_SF, 1'b0);
    meas(99999, 20, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    meas(100000, 20, 1'b1, K_NO, 4'h0, D_OV, 1'b0);
    wr(`LBS_CTRL_OFS, 32'h3);
    meas(100000, 20, 1'b0, K_BN, 4'h1, D_BN, 1'b0);
    wr(`LBS_LOW_CAP_INDICATION_PCT_OFS, 32'h1);
    wr(`LBS_CTRL_OFS, 32'h601);
    meas(100000, 0, 1'b0, K_BN, 4'h1, D_BN, 1'b0);
    wr(`LBS_CTRL_OFS, 32'h605);
    meas(100000, 0, 1'b0, K_BN, 4'h1, D_LC, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(`LBS_CTRL_OFS, lc_ctrl[i]);
      meas(lc_bd[i], 0, 1'b0, K_NR, 4'h0, D_LC, 1'b1);
      meas(lc_bd[i] + 1, 0, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    end
    meas(10, 0, 1'b1, K_NO, 4'h0, D_OV, 1'b0);
    wr(`LBS_REF_OFS, 32'd1000000);
    wr(`LBS_PRI_LO_BASE, -32'sd20000);
    wr(`LBS_PRI_HI_BASE, -32'sd10000);
    wr(`LBS_CTRL_OFS, 32'h11);
    meas(985000, 0, 1'b0, K_BN, 4'h1, D_BN, 1'b0);
    meas(990001, 0, 1'b0, K_NR, 4'h0, D_NR, 1'b0);
    wr(`LBS_PRI_LO_BASE, -32'sd200);
    wr(`LBS_PRI_HI_BASE, -32'sd100);
    wr(`LBS_CTRL_OFS, 32'h21);
    meas(985000, 0, 1'b0, K_BN, 4'h1, D_BN, 1'b0);
    wr(`LBS_CTRL_OFS, 32'h4);
    meas(10, 0, 1'b0, K_NO, 4'h0, lbs_pkg::DISP_NONE, 1'b1);
    summarize();
  end
endmodule
